// ===== rtl/stp_pkg.sv
package stp_pkg;
    // Clock and serial-clock timing
    localparam int STP_CLK_MHZ = 200;
    localparam int STP_SC_MAX_KHZ = 2500;
    // Half serial period in cycles, rounded up so the rate never exceeds the maximum
    localparam int STP_SC_HALF = (STP_CLK_MHZ * 1000 + 2 * STP_SC_MAX_KHZ - 1)
                                 / (2 * STP_SC_MAX_KHZ);
    localparam int STP_DIV_W = 8;

    // Frame geometry
    localparam logic [4:0] STP_SHORT_BITS = 5'd7;
    localparam logic [4:0] STP_CMD_BITS = 5'd8;
    localparam logic [4:0] STP_FRAME_BITS = 5'd16;

    // Temperature format
    localparam int STP_TEMP_W = 11;
    localparam int STP_COHERE_BIT = 4;
    localparam logic [STP_TEMP_W-1:0] STP_TEMP_RST = 11'h000;

    // Read-only register read codes
    localparam logic [7:0] STP_RD_TEMP_LO = 8'h81;
    localparam logic [7:0] STP_RD_TEMP_HI = 8'h83;
    localparam logic [7:0] STP_RD_STATUS = 8'h85;
    localparam logic [7:0] STP_RD_TACH = 8'haf;
    localparam logic [7:0] STP_RD_MAKER = 8'hfd;
    localparam logic [7:0] STP_RD_PART = 8'hff;

    // Seven-bit single-byte command codes (command byte without its last bit)
    localparam logic [6:0] STP_SHORT_ONESHOT = 7'h4f;
    localparam logic [6:0] STP_SHORT_SOFTRST = 7'h7c;

    // Writable register slots
    localparam int STP_NREG = 13;
    localparam int STP_I_CFG = 0;
    localparam int STP_I_UPPER = 5;
    localparam int STP_I_LOWER = 6;
    localparam int STP_I_SHDN = 2;
    localparam int STP_I_RELEASE = 3;
    localparam int STP_CFG_ALERT_MASK = 7;

    // Slots: cfg, fan rate, shutdown, release, fan thr, upper, lower, fan speed,
    // fan gain, tach limit, tach divisor, full scale, adc mode
    localparam logic [7:0] STP_RD_CODE [STP_NREG] = '{
        8'h87, 8'h89, 8'ha1, 8'ha3, 8'ha9, 8'h8f, 8'h91, 8'hab, 8'had, 8'hb1, 8'hbb,
        8'hbf, 8'hf5};
    localparam logic [7:0] STP_WR_CODE [STP_NREG] = '{
        8'h92, 8'h94, 8'ha4, 8'ha6, 8'hb2, 8'h9a, 8'h9c, 8'hb4, 8'hb6, 8'hb8, 8'hbc,
        8'hc0, 8'hf6};
    localparam logic [7:0] STP_RST_VAL [STP_NREG] = '{
        8'h00, 8'h02, 8'h64, 8'h5f, 8'h3c, 8'h7f, 8'hc9, 8'h00, 8'h80, 8'hff, 8'h01,
        8'hff, 8'h00};

    // Host engine states
    typedef enum logic [2:0] {STP_H_IDLE, STP_H_LOW, STP_H_HIGH, STP_H_TAIL,
                              STP_H_GAP} stp_hstate_t;
endpackage

// ===== rtl/stp_if.sv
`timescale 1ns/1ps
interface stp_if;
    // Wires driven by the host end
    logic serial_clock;
    logic select_n;
    logic serial_data_in;
    // Device data output and its enable
    logic sdo_out;
    logic sdo_oe;
    // Resolved data line, pulled high while nobody drives it
    logic serial_data_out;
    assign serial_data_out = sdo_oe ? sdo_out : 1'b1;

    modport dev (input serial_clock, input select_n, input serial_data_in,
                 output sdo_out, output sdo_oe);
    modport host (output serial_clock, output select_n, output serial_data_in,
                  input serial_data_out);
endinterface

// ===== rtl/stp_sync.sv
`timescale 1ns/1ps
module stp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous inputs and their synchronised copies
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // Two flip-flops per bit; the first is read only by the second
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q <= INIT[i];
                q[i] <= INIT[i];
            end else begin
                meta_q <= d[i];
                q[i] <= meta_q;
            end
        end
    end
endmodule

// ===== rtl/stp_device.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) Host masters clock, mode zero, 2.5 MHz
// (RULE2) Sample data on rising clock while selected
// (RULE3) Normal frame: command byte, data byte
// (RULE4) Command last bit: one read, zero write
// (RULE5) Deselected: ignore link, reset port state
// (RULE6) Read: drive MSB after eighth falling edge
// (RULE7) Read: shift remaining bits on falling edges
// (RULE8) Short read returns truncated data only
// (RULE9) Write: data on rises 9-16, commit fall 16
// (RULE10) Write cut short leaves register unchanged
// (RULE11) Host holds select until sixteenth fall
// (RULE12) Output undriven during whole write
// (RULE13) Seven-bit commands execute on seventh fall
// (RULE14) Separate read and write codes per register
// (RULE15) One-shot starts conversion; soft reset command
// (RULE16) Eleven-bit temperature split high/low bytes
// (RULE17) Low byte bit four flags coherence
// (RULE18) Host reads high byte before low
// (RULE19) Thresholds are whole-degree two's complement
// (RULE20) Alert at or above upper, below lower
// (RULE21) Shutdown flag at or above limit
// (RULE22) Thresholds reset to 127, -55, 100, 95
// (RULE23) One-shot ignored while converting
// (RULE24) Soft reset restores writable power-on values
module stp_device #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] PART_ID = 8'ha5 // arbitrary value
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Serial link
    stp_if.dev LINK,
    // Measurement side
    input wire logic [stp_pkg::STP_TEMP_W-1:0] TEMP_RESULT,
    input wire logic CONV_DONE,
    input wire logic [7:0] FAULT_STATUS,
    input wire logic [7:0] TACH_PERIOD,
    output logic CONV_START,
    // Alarm and configuration outputs
    output logic ALERT,
    output logic SHUTDOWN_FLAG_OUT,
    output logic [7:0] CONFIG_BYTE
);
    import stp_pkg::*;

    logic [2:0] pins_s; // Synchronised clock, select, data
    logic sc_s; // Serial clock level
    logic sel_n_s; // Select level, active low
    logic serial_data_in_s; // Serial data level
    logic sc_prev_q; // Clock level one cycle ago
    logic sc_rise; // Rising edge while selected
    logic sc_fall; // Falling edge while selected
    logic [4:0] cnt_q; // Rising edges seen in this frame
    logic [7:0] in_sh_q; // Input shift register
    logic [7:0] cmd_q; // Captured command byte
    logic [7:0] out_sh_q; // Output shift register
    logic sdo_q; // Data out
    logic oe_q; // Data out enable
    logic wr_stb; // Commit a write this cycle
    logic short_stb; // Seven-bit command completes this cycle
    logic rd_load; // Load read data this cycle
    logic oneshot_hit; // One-shot command decoded
    logic softrst_hit; // Soft reset command decoded
    logic [7:0] regs_q [STP_NREG]; // Writable registers
    logic [STP_TEMP_W-1:0] temp_q; // Last conversion result
    logic hi_fresh_q; // High byte read since the last result or low-byte read
    logic busy_q; // Conversion in progress
    logic start_q; // Conversion start pulse
    logic alert_q; // Alert level
    logic shdn_q; // Shutdown level
    logic [7:0] rd_data; // Read multiplexer output
    logic signed [7:0] temp_int; // Whole-degree temperature

    // Pins cross into the clock domain; select idles high
    stp_sync #(.W(3), .INIT(3'b010)) u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .d({LINK.serial_clock, LINK.select_n, LINK.serial_data_in}),
        .q(pins_s)
    );
    assign sc_s = pins_s[2];
    assign sel_n_s = pins_s[1];
    assign serial_data_in_s = pins_s[0];

    // Previous clock level for edge detection
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sc_prev_q <= 1'b0;
        end else begin
            sc_prev_q <= sc_s;
        end
    end

    // (RULE5) edges only while selected
    assign sc_rise = sc_s & ~sc_prev_q & ~sel_n_s;
    assign sc_fall = ~sc_s & sc_prev_q & ~sel_n_s;

    // Strobes decoded from edge and bit position
    // (RULE9) commit on sixteenth fall only
    // (RULE10) cut writes never commit
    assign wr_stb = sc_fall && (cnt_q == STP_FRAME_BITS) && !cmd_q[0];
    // (RULE13) seventh fall executes short commands
    assign short_stb = sc_fall && (cnt_q == STP_SHORT_BITS);
    // (RULE4) last bit one means read
    assign rd_load = sc_fall && (cnt_q == STP_CMD_BITS) && cmd_q[0];
    // (RULE15) short command decode
    assign oneshot_hit = short_stb && (in_sh_q[6:0] == STP_SHORT_ONESHOT);
    assign softrst_hit = short_stb && (in_sh_q[6:0] == STP_SHORT_SOFTRST);

    // Bit counter and input shifting
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= 5'd0;
            in_sh_q <= 8'h00;
            cmd_q <= 8'h00;
        end else if (sel_n_s) begin
            // (RULE5) deselect resets the port
            cnt_q <= 5'd0;
        end else if (sc_rise && cnt_q != STP_FRAME_BITS) begin
            // (RULE3) count stops at sixteen
            // (RULE2) sample on rising edge
            cnt_q <= cnt_q + 5'd1;
            in_sh_q <= {in_sh_q[6:0], serial_data_in_s};
            if (cnt_q == STP_CMD_BITS - 5'd1) begin
                // Command byte complete on eighth rise
                cmd_q <= {in_sh_q[6:0], serial_data_in_s};
            end
        end
    end

    // Data output path
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sdo_q <= 1'b1;
            oe_q <= 1'b0;
            out_sh_q <= 8'h00;
        end else if (sel_n_s) begin
            // (RULE12) released when deselected and during writes
            oe_q <= 1'b0;
        end else if (rd_load) begin
            // (RULE6) MSB driven after eighth fall
            oe_q <= 1'b1;
            sdo_q <= rd_data[7];
            out_sh_q <= {rd_data[6:0], 1'b0};
        end else if (sc_fall && oe_q && cnt_q < STP_FRAME_BITS) begin
            // (RULE7) next bit on each falling edge
            sdo_q <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
    end
    assign LINK.sdo_out = sdo_q;
    assign LINK.sdo_oe = oe_q;

    // Writable registers, one slot per register
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            // (RULE22) threshold power-on values
            for (int i = 0; i < STP_NREG; i++) begin
                regs_q[i] <= STP_RST_VAL[i];
            end
        end else if (softrst_hit) begin
            // (RULE24) soft reset restores defaults
            for (int i = 0; i < STP_NREG; i++) begin
                regs_q[i] <= STP_RST_VAL[i];
            end
        end else if (wr_stb) begin
            // (RULE14) own write code per register
            for (int i = 0; i < STP_NREG; i++) begin
                if (cmd_q == STP_WR_CODE[i]) begin
                    regs_q[i] <= in_sh_q;
                end
            end
        end
    end

    // Conversion request and busy tracking
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            busy_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            // (RULE23) one-shot ignored while busy
            start_q <= oneshot_hit && !busy_q;
            if (oneshot_hit && !busy_q) begin
                busy_q <= 1'b1;
            end else if (CONV_DONE) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Temperature result and coherence tracking
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            temp_q <= STP_TEMP_RST;
            hi_fresh_q <= 1'b0;
        end else if (CONV_DONE) begin
            // (RULE16) new result invalidates pairing
            temp_q <= TEMP_RESULT;
            hi_fresh_q <= 1'b0;
        end else if (rd_load && cmd_q == STP_RD_TEMP_HI) begin
            // (RULE17) high byte read first
            hi_fresh_q <= 1'b1;
        end else if (rd_load && cmd_q == STP_RD_TEMP_LO) begin
            hi_fresh_q <= 1'b0;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_data = 8'h00;
        case (cmd_q)
            // (RULE16) sign and upper seven bits
            STP_RD_TEMP_HI: rd_data = temp_q[10:3];
            // (RULE17) three low bits plus coherence flag
            STP_RD_TEMP_LO: rd_data = {temp_q[2:0], ~hi_fresh_q, 4'h0};
            STP_RD_STATUS: rd_data = FAULT_STATUS;
            STP_RD_TACH: rd_data = TACH_PERIOD;
            STP_RD_MAKER: rd_data = MAKER_ID;
            STP_RD_PART: rd_data = PART_ID;
            default: begin
                for (int i = 0; i < STP_NREG; i++) begin
                    if (cmd_q == STP_RD_CODE[i]) begin
                        rd_data = regs_q[i];
                    end
                end
            end
        endcase
    end

    // (RULE19) whole-degree comparisons
    assign temp_int = $signed(temp_q[10:3]);

    // Alarm comparisons against thresholds
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            alert_q <= 1'b0;
            shdn_q <= 1'b0;
        end else begin
            // (RULE20) upper inclusive, lower strict
            alert_q <= !regs_q[STP_I_CFG][STP_CFG_ALERT_MASK] &&
                       ((temp_int >= $signed(regs_q[STP_I_UPPER])) ||
                        (temp_int < $signed(regs_q[STP_I_LOWER])));
            // (RULE21) set at limit, clear below release
            if (temp_int >= $signed(regs_q[STP_I_SHDN])) begin
                shdn_q <= 1'b1;
            end else if (temp_int < $signed(regs_q[STP_I_RELEASE])) begin
                shdn_q <= 1'b0;
            end
        end
    end

    // Registered user-side outputs
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            CONFIG_BYTE <= STP_RST_VAL[STP_I_CFG];
        end else begin
            CONFIG_BYTE <= regs_q[STP_I_CFG];
        end
    end
    assign CONV_START = start_q;
    assign ALERT = alert_q;
    assign SHUTDOWN_FLAG_OUT = shdn_q;
endmodule

// ===== rtl/stp_host.sv
`timescale 1ns/1ps
module stp_host (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Serial link
    stp_if.host LINK,
    // Request side
    input wire logic REQ,
    input wire logic [7:0] CMD,
    input wire logic [7:0] WDATA,
    input wire logic [4:0] NBITS,
    // Answer side
    output logic BUSY,
    output logic DONE,
    output logic [7:0] RDATA
);
    import stp_pkg::*;

    stp_hstate_t state_q; // Frame sequencer state
    logic [STP_DIV_W-1:0] div_q; // Half-period divider
    logic tick; // One-cycle half-period enable
    logic [15:0] tx_q; // Bits still to send, MSB first
    logic [7:0] rx_q; // Bits captured from the device
    logic [4:0] sent_q; // Clock pulses issued
    logic [4:0] nbits_q; // Frame length
    logic sc_q; // Serial clock
    logic sel_n_q; // Select, active low
    logic sdi_q; // Data to device
    logic done_q; // Completion pulse
    logic busy_q; // Frame in progress
    logic sdo_s; // Synchronised device data

    // Device data line crosses into the clock domain; idles high
    stp_sync #(.W(1), .INIT(1'b1)) u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .d(LINK.serial_data_out),
        .q(sdo_s)
    );

    // Divider runs only inside a frame
    assign tick = (div_q == STP_DIV_W'(STP_SC_HALF - 1));
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= '0;
        end else if (state_q == STP_H_IDLE || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // (RULE1) mode zero clock at or below maximum rate
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= STP_H_IDLE;
            sc_q <= 1'b0;
            sel_n_q <= 1'b1;
            sdi_q <= 1'b0;
            tx_q <= 16'h0000;
            rx_q <= 8'h00;
            sent_q <= 5'd0;
            nbits_q <= 5'd0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            RDATA <= 8'h00;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                // Accept a request and present the first bit
                STP_H_IDLE: begin
                    if (REQ) begin
                        busy_q <= 1'b1;
                        sel_n_q <= 1'b0;
                        sdi_q <= CMD[7];
                        tx_q <= {CMD[6:0], WDATA, 1'b0};
                        nbits_q <= NBITS;
                        sent_q <= 5'd0;
                        state_q <= STP_H_LOW;
                    end
                end
                // Raise the clock and capture device data
                STP_H_LOW: begin
                    if (tick) begin
                        sc_q <= 1'b1;
                        rx_q <= {rx_q[6:0], sdo_s};
                        sent_q <= sent_q + 5'd1;
                        state_q <= STP_H_HIGH;
                    end
                end
                // Lower the clock and change data
                STP_H_HIGH: begin
                    if (tick) begin
                        sc_q <= 1'b0;
                        if (sent_q == nbits_q) begin
                            state_q <= STP_H_TAIL;
                        end else begin
                            sdi_q <= tx_q[15];
                            tx_q <= {tx_q[14:0], 1'b0};
                            state_q <= STP_H_LOW;
                        end
                    end
                end
                // (RULE11) select held past last falling edge
                STP_H_TAIL: begin
                    if (tick) begin
                        sel_n_q <= 1'b1;
                        state_q <= STP_H_GAP;
                    end
                end
                // Deselected gap before the next frame
                STP_H_GAP: begin
                    if (tick) begin
                        // (RULE8) short read keeps partial bits
                        RDATA <= rx_q;
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= STP_H_IDLE;
                    end
                end
                default: state_q <= STP_H_IDLE;
            endcase
        end
    end

    assign LINK.serial_clock = sc_q;
    assign LINK.select_n = sel_n_q;
    assign LINK.serial_data_in = sdi_q;
    assign BUSY = busy_q;
    assign DONE = done_q;
endmodule

// ===== tb/stp_asserts.sv
`timescale 1ns/1ps
// Watches the serial link between the host end and the device end
module stp_asserts (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Link wires
    input wire logic serial_clock,
    input wire logic select_n,
    input wire logic serial_data_in,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic serial_data_out
);
    import stp_pkg::*;
    logic sc_q; // Link clock one cycle ago
    logic [7:0] age_q; // Cycles since the link clock last moved
    logic [4:0] rise_q; // Rising link edges in this frame
    logic lsb_q; // Direction bit of the command byte
    logic rise; // Link clock rising now
    assign rise = serial_clock && !sc_q;
    // Edge age, saturating so long idle gaps never wrap
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sc_q <= 1'b0;
            age_q <= 8'h00;
        end else begin
            sc_q <= serial_clock;
            age_q <= (serial_clock != sc_q) ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
        end
    end
    // Frame position and direction bit
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rise_q <= 5'h00;
            lsb_q <= 1'b0;
        end else if (select_n) begin
            rise_q <= 5'h00;
        end else if (rise) begin
            rise_q <= rise_q + 5'h01;
            if (rise_q == 5'd7) begin
                lsb_q <= serial_data_in;
            end
        end
    end
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    // Eighth falling edge of a read frame
    sequence s_read_turn;
        $fell(serial_clock) && !select_n && rise_q == 5'd8 && lsb_q;
    endsequence
    idle_clock_low_a: assert property (select_n |-> !serial_clock)
        else $error("link clock moved while deselected");
    clock_rate_a: assert property (
        $changed(serial_clock) |-> age_q >= 8'(STP_SC_HALF - 2))
        else $error("link clock half period too short");
    data_setup_a: assert property ($rose(serial_clock) |-> $stable(serial_data_in))
        else $error("data in moved at the sampling edge");
    frame_len_a: assert property (!select_n |-> rise_q <= STP_FRAME_BITS)
        else $error("more than sixteen clocks in a frame");
    drive_cause_a: assert property ($rose(sdo_oe) |-> lsb_q && rise_q == 5'd8)
        else $error("data out driven outside a read turn");
    release_a: assert property ($rose(select_n) |-> ##[1:6] !sdo_oe)
        else $error("data out still driven after deselect");
    read_drive_a: assert property (s_read_turn |-> ##[1:6] sdo_oe)
        else $error("read data not driven after eighth fall");
    shift_fall_a: assert property (
        sdo_oe && $past(sdo_oe) && !select_n && $changed(sdo_out)
        |-> !serial_clock && age_q <= 8'd8)
        else $error("read bit changed away from a falling edge");
    write_quiet_a: assert property (
        !select_n && !lsb_q && rise_q >= 5'd8 |-> !sdo_oe)
        else $error("data out driven during a write");
endmodule

// ===== tb/test_serial_register_port_temp_alarms.sv
`timescale 1ns/1ps
// Host and device ends on one link, checked against a register model
module test_serial_register_port_temp_alarms;
    import stp_pkg::*;
    localparam logic [7:0] MAKER = 8'h3a; // Arbitrary identity value
    localparam logic [7:0] PART = 8'hc6; // Arbitrary identity value
    // Design inputs, all set at time zero
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [4:0] nbits = 5'd16;
    logic [10:0] temp_result = 11'h000;
    logic conv_done = 1'b0;
    logic [7:0] fault_status = 8'h00;
    logic [7:0] tach_period = 8'h00;
    // Design outputs
    logic busy, done, conv_start, alert, shut_out;
    logic [7:0] rdata, config_byte;
    // Model state and bookkeeping
    logic [7:0] regs [STP_NREG];
    logic [10:0] temps [7] = '{11'h000, 11'h320, 11'h300, 11'h2f0, 11'h3f8, 11'h648, 11'h647};
    logic [7:0] r;
    logic [10:0] t;
    logic shut_m = 1'b0;
    int fail_count = 0;
    int checked = 0;
    int starts = 0;
    int cyc = 0;
    int n;
    stp_if link();
    stp_host u_stp_host (.CLOCK(clock), .RST_N(rst_n), .LINK(link), .REQ(req), .CMD(cmd),
        .WDATA(wdata), .NBITS(nbits), .BUSY(busy), .DONE(done), .RDATA(rdata));
    stp_device #(.MAKER_ID(MAKER), .PART_ID(PART)) u_stp_device (.CLOCK(clock),
        .RST_N(rst_n), .LINK(link), .TEMP_RESULT(temp_result), .CONV_DONE(conv_done),
        .FAULT_STATUS(fault_status), .TACH_PERIOD(tach_period), .CONV_START(conv_start),
        .ALERT(alert), .SHUTDOWN_FLAG_OUT(shut_out), .CONFIG_BYTE(config_byte));
    stp_asserts u_stp_asserts (.CLOCK(clock), .RST_N(rst_n),
        .serial_clock(link.serial_clock), .select_n(link.select_n),
        .serial_data_in(link.serial_data_in), .sdo_out(link.sdo_out),
        .sdo_oe(link.sdo_oe), .serial_data_out(link.serial_data_out));
    // Free-running clock
    initial begin
        forever #2.5 clock = ~clock;
    end
    // Count start pulses and cut a hang short
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (conv_start === 1'b1) begin
            starts = starts + 1;
        end
        if (cyc == 95000) begin
            fail_count++;
            print_verdict();
        end
    end
    // Verdict and end of run
    task automatic print_verdict;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Compare a seen value with its expectation
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One host frame; the read byte lands in r
    task automatic frame(input logic [7:0] c, input logic [7:0] d, input logic [4:0] nb);
        @(posedge clock);
        req <= 1'b1;
        cmd <= c;
        wdata <= d;
        nbits <= nb;
        @(posedge clock);
        req <= 1'b0;
        @(negedge clock);
        check({7'h00, busy}, 8'h01);
        for (int i = 0; i < 3000 && done !== 1'b1; i++) begin
            @(negedge clock);
        end
        r = rdata;
        check({7'h00, busy}, 8'h00);
    endtask
    // Full read compared with the model
    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        frame(c, 8'h00, 5'd16);
        check(r, exp);
    endtask
    // New conversion result on a one-cycle done pulse
    task automatic convert(input logic [10:0] v);
        @(posedge clock);
        temp_result <= v;
        conv_done <= 1'b1;
        @(posedge clock);
        conv_done <= 1'b0;
    endtask
    // Apply a temperature and compare both alarm outputs with the model
    task automatic alarm(input logic [10:0] v);
        int tv;
        tv = int'($signed(v));
        convert(v);
        repeat (4) @(negedge clock);
        if (tv >= int'($signed(regs[STP_I_SHDN])) * 8) begin
            shut_m = 1'b1;
        end else if (tv < int'($signed(regs[STP_I_RELEASE])) * 8) begin
            shut_m = 1'b0;
        end
        check({7'h00, alert}, {7'h00, (tv >= int'($signed(regs[STP_I_UPPER])) * 8
            || tv < int'($signed(regs[STP_I_LOWER])) * 8) && !regs[STP_I_CFG][7]});
        check({7'h00, shut_out}, {7'h00, shut_m});
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h1ffa26b2));
        for (int i = 0; i < STP_NREG; i++) begin
            regs[i] = STP_RST_VAL[i];
        end
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        fault_status <= 8'($urandom);
        tach_period <= 8'($urandom);
        rd(8'h8f, 8'h7f);
        rd(8'h91, 8'hc9);
        rd(8'ha1, 8'h64);
        rd(8'ha3, 8'h5f);
        rd(8'h87, 8'h00);
        rd(8'hfd, MAKER);
        rd(8'hff, PART);
        rd(8'h85, fault_status);
        rd(8'haf, tach_period);
        rd(8'h01, 8'h00);
        // One-shot, a refused repeat while converting, then one more
        n = starts;
        frame(8'h9e, 8'h00, 5'd7);
        check(8'(starts - n), 8'd1);
        frame(8'h9e, 8'h00, 5'd7);
        check(8'(starts - n), 8'd1);
        convert(11'h000);
        frame(8'h9e, 8'h00, 5'd7);
        check(8'(starts - n), 8'd2);
        // Temperature bytes and the coherence flag; high byte read first
        t = 11'($urandom);
        convert(t);
        rd(STP_RD_TEMP_HI, t[10:3]);
        rd(STP_RD_TEMP_LO, {t[2:0], 5'h00});
        rd(STP_RD_TEMP_LO, {t[2:0], 5'h10});
        rd(STP_RD_TEMP_HI, t[10:3]);
        convert(~t);
        rd(STP_RD_TEMP_LO, {~t[2:0], 5'h10});
        // Every writable register written and read back
        for (int i = 0; i < STP_NREG; i++) begin
            regs[i] = 8'($urandom) & ((i == STP_I_CFG) ? 8'hef : 8'hff);
            frame(STP_WR_CODE[i], regs[i], 5'd16);
        end
        for (int i = 0; i < STP_NREG; i++) begin
            rd(STP_RD_CODE[i], regs[i]);
        end
        check(config_byte, regs[STP_I_CFG]);
        // Cut write, then cut read
        frame(8'h9a, ~regs[STP_I_UPPER], 5'd15);
        rd(8'h8f, regs[STP_I_UPPER]);
        frame(8'h8f, 8'h00, 5'd12);
        check(r, {4'hf, regs[STP_I_UPPER][7:4]});
        // Soft reset restores every writable register
        frame(8'hf8, 8'h00, 5'd7);
        for (int i = 0; i < STP_NREG; i++) begin
            regs[i] = STP_RST_VAL[i];
            rd(STP_RD_CODE[i], regs[i]);
        end
        // Alarm boundaries, then a lowered upper limit
        for (int i = 0; i < 7; i++) begin
            alarm(temps[i]);
        end
        regs[STP_I_UPPER] = 8'h10;
        frame(8'h9a, 8'h10, 5'd16);
        alarm(11'h080);
        alarm(11'h07f);
        print_verdict();
    end
endmodule
